/* File: core/tea_pkg.sv */
// Constants, types and carriers for the translation enable and
// acknowledge block.
// Assumes a 32-bit APB slave port and one system clock.
package tea_pkg;

	// -----------------------------------------------------------------
	// Register map (byte addresses)
	// -----------------------------------------------------------------
	localparam logic [11:0] TEA_OFF_CONTROL     = 12'h020;
	localparam logic [11:0] TEA_OFF_CONTROL_ACK = 12'h024;
	localparam logic [11:0] TEA_OFF_BYPASS      = 12'h030;

	// -----------------------------------------------------------------
	// Field positions of control, acknowledge and bypass
	// -----------------------------------------------------------------
	localparam int TEA_BIT_TRANS_EN  = 0;
	localparam int TEA_BIT_PRIQ_EN   = 1;
	localparam int TEA_BIT_EVTQ_EN   = 2;
	localparam int TEA_BIT_CMDQ_EN   = 3;
	localparam int TEA_BIT_ATS_CHECK = 4;
	localparam int TEA_VMW_LSB       = 6;
	localparam int TEA_VMW_MSB       = 8;
	localparam int TEA_BIT_BYP_ABORT = 0;

	// -----------------------------------------------------------------
	// Reset values and limits
	// -----------------------------------------------------------------
	localparam logic       TEA_RST_BIT     = 1'h0;
	localparam logic [2:0] TEA_RST_VMW     = 3'h0;
	localparam logic [2:0] TEA_VMW_MAX     = 3'h4;
	localparam logic [31:0] TEA_RST_PRDATA = 32'h0000_0000;

	// -----------------------------------------------------------------
	// Enumerations
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {
		TEA_EN_OFF, TEA_EN_ON_PEND, TEA_EN_ON, TEA_EN_OFF_PEND
	} tea_en_state_t;

	typedef enum logic [2:0] {
		TEA_TXN_NORMAL, TEA_TXN_ATS_XLATED, TEA_TXN_ATS_REQ,
		TEA_TXN_PRI_REQ, TEA_TXN_INV_CPL
	} tea_txn_kind_t;

	typedef enum logic [2:0] {
		TEA_RSP_TRANSLATE, TEA_RSP_BYPASS, TEA_RSP_ABORT,
		TEA_RSP_UNSUP_REQ, TEA_RSP_DISCARD, TEA_RSP_PASS_DIRECT,
		TEA_RSP_CHECK_ENTRY, TEA_RSP_OTHER_SIDE
	} tea_txn_rsp_t;

	typedef enum logic [1:0] {
		TEA_ATC_INVALIDATE_CMD, TEA_PAGE_REQUEST_RESPONSE_CMD, TEA_CMD_PREFETCH, TEA_CMD_OTHER
	} tea_cmd_kind_t;

	// -----------------------------------------------------------------
	// Carriers
	// -----------------------------------------------------------------
	typedef struct packed {
		logic          valid;
		tea_txn_kind_t kind;
		logic          secure;
		logic          substream;
	} tea_txn_req_t;

	typedef struct packed {
		logic         valid;
		tea_txn_rsp_t resp;
	} tea_txn_out_t;

	typedef struct packed {
		logic          valid;
		tea_cmd_kind_t kind;
	} tea_cmd_req_t;

	typedef struct packed {
		logic valid;
		logic accept;
	} tea_cmd_out_t;

	typedef struct packed {
		logic       trans_en;
		logic       priq_en;
		logic       evtq_en;
		logic       cmdq_en;
		logic       ats_check;
		logic [2:0] vmid_wildcard;
	} tea_fields_t;

endpackage : tea_pkg

/* File: core/tea_top.sv */
// Translation enable, bypass gating and control acknowledge logic.
// Assumes APB master on the same clock, and that the stall, address
// translation operation and page request units report idle levels.
`timescale 1ns/1ps

// Contract
// - Off, no abort: pass untranslated with bypass
// - Off, abort set: abort matching transactions
// - Off: translation requests get unsupported status
// - Off: ignore invalidate, response, completion messages
// - Off: page request queue effectively off, discard
// - Off: translated transactions are aborted
// - Off: no stream table fetches
// - Off: no cache fills except invalidations
// - Off: no table updates, prefetch fills nothing
// - Off: no translation events, no software ops
// - Command and event queues still follow their own enables
// - Enable ack waits for setup and idle ops
// - Disable ack waits for stall abort, tags
// - Disable ack waits for software op end
// - Disable ack after page queue off, bypass
// - Each transaction sees one enable value
// - Enable change leaves caches untouched
// - Secure side traffic never affected
// - Wildcard codes zero to four, else zero
// - Wildcard only for invalidation matching
// - Check mode selects direct pass or check
// - Ack bits: command three, event two
// - Ack field follows after update completes
module tea_top (
	input  wire logic                  CLK_I,
	input  wire logic                  ARST_N_I,
	input  wire logic                  PSEL_I,
	input  wire logic                  PENABLE_I,
	input  wire logic                  PWRITE_I,
	input  wire logic [11:0]           PADDR_I,
	input  wire logic [31:0]           PWDATA_I,
	input  wire logic [3:0]            PSTRB_I,
	output      logic [31:0]           PRDATA_O,
	output      logic                  PREADY_O,
	output      logic                  PSLVERR_O,
	input  wire tea_pkg::tea_txn_req_t TXN_I,
	output      tea_pkg::tea_txn_out_t TXN_O,
	input  wire tea_pkg::tea_cmd_req_t CMD_I,
	output      tea_pkg::tea_cmd_out_t CMD_O,
	input  wire logic                  CR2_APPLIED_I,
	input  wire logic                  SOFTWARE_TRANSLATION_OP_RUN_I,
	input  wire logic                  SOFTWARE_TRANSLATION_OP_IDLE_I,
	input  wire logic                  STALL_DONE_I,
	input  wire logic                  PRIQ_IDLE_I,
	input  wire logic                  CMDQ_IDLE_I,
	input  wire logic                  EVTQ_IDLE_I,
	output      logic                  STALL_ABORT_O,
	output      logic                  SOFTWARE_TRANSLATION_OP_ABORT_O,
	output      logic                  WALK_ALLOW_O,
	output      logic                  EVENT_XLATE_EN_O,
	output      logic                  SOFTWARE_TRANSLATION_OP_ALLOW_O,
	output      logic                  PRIQ_WRITE_EN_O,
	output      logic                  CMDQ_RUN_O,
	output      logic                  EVTQ_WRITE_O,
	output      logic [2:0]            INV_VMID_IGNORE_O
);
	import tea_pkg::*;

	// -----------------------------------------------------------------
	// State
	// -----------------------------------------------------------------
	typedef struct packed {
		tea_fields_t   ctrl;
		tea_fields_t   ack;
		logic          byp_abort;
		tea_en_state_t en_st;
		logic          en_eff;
		logic          stall_abort;
		logic          software_translation_op_abort;
		logic          priq_wr;
		logic [2:0]    inv_ignore;
		logic [31:0]   prdata;
		logic          pready;
		logic          pslverr;
		tea_txn_out_t  txn;
		tea_cmd_out_t  cmd;
	} tea_state_t;

	localparam tea_fields_t TEA_RST_FIELDS = '{
		trans_en: TEA_RST_BIT, priq_en: TEA_RST_BIT,
		evtq_en: TEA_RST_BIT, cmdq_en: TEA_RST_BIT,
		ats_check: TEA_RST_BIT, vmid_wildcard: TEA_RST_VMW};

	tea_state_t s;
	tea_state_t next_s;

	// Register image of a field set; bit 5 and bits 31:9 stay zero
	function automatic logic [31:0] tea_pack(input tea_fields_t f);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[TEA_BIT_TRANS_EN]         = f.trans_en;
		w[TEA_BIT_PRIQ_EN]          = f.priq_en;
		w[TEA_BIT_EVTQ_EN]          = f.evtq_en;
		w[TEA_BIT_CMDQ_EN]          = f.cmdq_en;
		w[TEA_BIT_ATS_CHECK]        = f.ats_check;
		w[TEA_VMW_MSB:TEA_VMW_LSB]  = f.vmid_wildcard;
		return w;
	endfunction : tea_pack

	logic apb_setup;
	logic apb_write;

	assign apb_setup = PSEL_I && !PENABLE_I;
	assign apb_write = PSEL_I && PENABLE_I && PWRITE_I && s.pready;

	always_comb begin
		next_s = s;
		next_s.txn.valid = 1'h0;
		next_s.cmd.valid = 1'h0;

		// -------------------------------------------------------------
		// APB: read data and error prepared in setup, zero wait access
		// -------------------------------------------------------------
		if (apb_setup) begin
			next_s.pready  = 1'h1;
			next_s.pslverr = 1'h0;
			case (PADDR_I)
				TEA_OFF_CONTROL: begin
					next_s.prdata = tea_pack(s.ctrl);
				end
				TEA_OFF_CONTROL_ACK: begin
					next_s.prdata = tea_pack(s.ack);
				end
				TEA_OFF_BYPASS: begin
					next_s.prdata = {31'h0000_0000, s.byp_abort};
				end
				default: begin
					next_s.prdata  = TEA_RST_PRDATA;
					next_s.pslverr = 1'h1;
				end
			endcase
		end
		if (apb_write) begin
			case (PADDR_I)
				TEA_OFF_CONTROL: begin
					if (PSTRB_I[0]) begin
						next_s.ctrl.trans_en  = PWDATA_I[TEA_BIT_TRANS_EN];
						next_s.ctrl.priq_en   = PWDATA_I[TEA_BIT_PRIQ_EN];
						next_s.ctrl.evtq_en   = PWDATA_I[TEA_BIT_EVTQ_EN];
						next_s.ctrl.cmdq_en   = PWDATA_I[TEA_BIT_CMDQ_EN];
						next_s.ctrl.ats_check = PWDATA_I[TEA_BIT_ATS_CHECK];
						next_s.ctrl.vmid_wildcard[1:0]  = PWDATA_I[7:6];
					end
					if (PSTRB_I[1]) begin
						next_s.ctrl.vmid_wildcard[2] = PWDATA_I[TEA_VMW_MSB];
					end
				end
				TEA_OFF_BYPASS: begin
					if (PSTRB_I[0]) begin
						next_s.byp_abort = PWDATA_I[TEA_BIT_BYP_ABORT];
					end
				end
				default: begin
					// Acknowledge is read only; writes leave it alone
				end
			endcase
		end

		// -------------------------------------------------------------
		// Translation enable update sequence
		// -------------------------------------------------------------
		// Caches are left as they are across either direction
		case (s.en_st)
			TEA_EN_OFF: begin
				if (s.ctrl.trans_en) begin
					next_s.en_st = TEA_EN_ON_PEND;
				end
			end
			TEA_EN_ON_PEND: begin
				if (!s.ctrl.trans_en) begin
					next_s.en_st = TEA_EN_OFF;
				end else if (CR2_APPLIED_I && !SOFTWARE_TRANSLATION_OP_RUN_I) begin
					next_s.en_eff       = 1'h1;
					next_s.ack.trans_en = 1'h1;
					next_s.en_st        = TEA_EN_ON;
				end
			end
			TEA_EN_ON: begin
				if (!s.ctrl.trans_en) begin
					// New traffic bypasses from here; stalls cannot start
					next_s.en_eff      = 1'h0;
					next_s.stall_abort = 1'h1;
					next_s.software_translation_op_abort  = 1'h1;
					next_s.en_st       = TEA_EN_OFF_PEND;
				end
			end
			TEA_EN_OFF_PEND: begin
				// A rewrite to one mid-sequence is ignored; this completes
				if (STALL_DONE_I && SOFTWARE_TRANSLATION_OP_IDLE_I && PRIQ_IDLE_I &&
				    !s.priq_wr) begin
					next_s.stall_abort  = 1'h0;
					next_s.software_translation_op_abort   = 1'h0;
					next_s.ack.trans_en = 1'h0;
					next_s.en_st        = TEA_EN_OFF;
				end
			end
			default: begin
				next_s.en_st = TEA_EN_OFF;
			end
		endcase
		next_s.priq_wr = s.ctrl.priq_en && next_s.en_eff;

		// -------------------------------------------------------------
		// Other fields: ack follows once side effects are done
		// -------------------------------------------------------------
		// Page request ack shows the written value, not the effective one
		if (s.ctrl.priq_en || PRIQ_IDLE_I) begin
			next_s.ack.priq_en = s.ctrl.priq_en;
		end
		if (s.ctrl.cmdq_en || CMDQ_IDLE_I) begin
			next_s.ack.cmdq_en = s.ctrl.cmdq_en;
		end
		if (s.ctrl.evtq_en || EVTQ_IDLE_I) begin
			next_s.ack.evtq_en = s.ctrl.evtq_en;
		end
		next_s.ack.ats_check = s.ctrl.ats_check;
		next_s.ack.vmid_wildcard       = s.ctrl.vmid_wildcard;
		// Reserved wildcard codes fall back to exact match
		if (s.ack.vmid_wildcard <= TEA_VMW_MAX) begin
			next_s.inv_ignore = s.ack.vmid_wildcard;
		end else begin
			next_s.inv_ignore = TEA_RST_VMW;
		end

		// -------------------------------------------------------------
		// Transaction decisions, one enable value per transaction
		// -------------------------------------------------------------
		if (TXN_I.valid) begin
			next_s.txn.valid = 1'h1;
			if (TXN_I.secure) begin
				next_s.txn.resp = TEA_RSP_OTHER_SIDE;
			end else if (!s.en_eff) begin
				case (TXN_I.kind)
					TEA_TXN_ATS_REQ: begin
						next_s.txn.resp = TEA_RSP_UNSUP_REQ;
					end
					TEA_TXN_ATS_XLATED: begin
						next_s.txn.resp = TEA_RSP_ABORT;
					end
					TEA_TXN_PRI_REQ, TEA_TXN_INV_CPL: begin
						next_s.txn.resp = TEA_RSP_DISCARD;
					end
					default: begin
						// Substream traffic bypasses or aborts the same way, as byp_abort selects
						next_s.txn.resp = s.byp_abort ? TEA_RSP_ABORT :
						                  TEA_RSP_BYPASS;
					end
				endcase
			end else begin
				case (TXN_I.kind)
					TEA_TXN_ATS_XLATED: begin
						next_s.txn.resp = s.ack.ats_check ?
						    TEA_RSP_CHECK_ENTRY : TEA_RSP_PASS_DIRECT;
					end
					TEA_TXN_PRI_REQ: begin
						next_s.txn.resp = s.priq_wr ? TEA_RSP_TRANSLATE :
						                  TEA_RSP_DISCARD;
					end
					default: begin
						next_s.txn.resp = TEA_RSP_TRANSLATE;
					end
				endcase
			end
		end

		// -------------------------------------------------------------
		// Commands: interface-side commands dropped while off
		// -------------------------------------------------------------
		if (CMD_I.valid) begin
			next_s.cmd.valid  = 1'h1;
			next_s.cmd.accept = s.en_eff ||
			                    (CMD_I.kind == TEA_CMD_OTHER);
		end
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			s.ctrl        <= TEA_RST_FIELDS;
			s.ack         <= TEA_RST_FIELDS;
			s.byp_abort   <= TEA_RST_BIT;
			s.en_st       <= TEA_EN_OFF;
			s.en_eff      <= TEA_RST_BIT;
			s.stall_abort <= TEA_RST_BIT;
			s.software_translation_op_abort  <= TEA_RST_BIT;
			s.priq_wr     <= TEA_RST_BIT;
			s.inv_ignore  <= TEA_RST_VMW;
			s.prdata      <= TEA_RST_PRDATA;
			s.pready      <= 1'h1;
			s.pslverr     <= TEA_RST_BIT;
			s.txn         <= '{valid: 1'h0, resp: TEA_RSP_BYPASS};
			s.cmd         <= '{valid: 1'h0, accept: 1'h0};
		end else begin
			s <= next_s;
		end
	end

	// -----------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------
	assign PRDATA_O          = s.prdata;
	assign PREADY_O          = s.pready;
	assign PSLVERR_O         = s.pslverr;
	assign TXN_O             = s.txn;
	assign CMD_O             = s.cmd;
	assign STALL_ABORT_O     = s.stall_abort;
	assign SOFTWARE_TRANSLATION_OP_ABORT_O      = s.software_translation_op_abort;
	// Table walks, fills, updates and prefetch all gate on this
	assign WALK_ALLOW_O      = s.en_eff;
	assign EVENT_XLATE_EN_O  = s.en_eff;
	assign SOFTWARE_TRANSLATION_OP_ALLOW_O      = s.en_eff;
	assign PRIQ_WRITE_EN_O   = s.priq_wr;
	assign CMDQ_RUN_O        = s.ack.cmdq_en;
	assign EVTQ_WRITE_O      = s.ack.evtq_en;
	// Lookup compares never see this mask, only invalidation does
	assign INV_VMID_IGNORE_O = s.inv_ignore;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	default clocking tea_cb @(posedge CLK_I); endclocking
	default disable iff (!ARST_N_I);

	a_bypass_when_off: assert property (
		TXN_I.valid && !TXN_I.secure && !s.en_eff && !s.byp_abort &&
		TXN_I.kind == TEA_TXN_NORMAL |=>
		TXN_O.valid && TXN_O.resp == TEA_RSP_BYPASS)
		else $error("off without abort did not bypass");

	a_abort_when_off: assert property (
		TXN_I.valid && !TXN_I.secure && !s.en_eff && s.byp_abort &&
		TXN_I.kind == TEA_TXN_NORMAL |=> TXN_O.resp == TEA_RSP_ABORT)
		else $error("off with abort did not abort");

	a_unsup_when_off: assert property (
		TXN_I.valid && !TXN_I.secure && !s.en_eff &&
		TXN_I.kind == TEA_TXN_ATS_REQ |=> TXN_O.resp == TEA_RSP_UNSUP_REQ)
		else $error("translation request not refused while off");

	a_cmd_drop_off: assert property (
		CMD_I.valid && !s.en_eff && CMD_I.kind != TEA_CMD_OTHER |=>
		CMD_O.valid && !CMD_O.accept)
		else $error("interface command accepted while off");

	a_priq_eff_off: assert property (
		!s.en_eff |-> !PRIQ_WRITE_EN_O)
		else $error("page queue writable while off");

	a_xlated_abort_off: assert property (
		TXN_I.valid && !TXN_I.secure && !s.en_eff &&
		TXN_I.kind == TEA_TXN_ATS_XLATED |=> TXN_O.resp == TEA_RSP_ABORT)
		else $error("translated traffic passed while off");

	a_walk_follows_ack: assert property (
		WALK_ALLOW_O |-> s.ack.trans_en && s.en_st == TEA_EN_ON)
		else $error("walks allowed without acknowledged enable");

	a_on_prereq: assert property (
		$rose(s.ack.trans_en) |-> $past(CR2_APPLIED_I) &&
		!$past(SOFTWARE_TRANSLATION_OP_RUN_I) && WALK_ALLOW_O)
		else $error("enable acknowledged before setup complete");

	a_off_prereq: assert property (
		$fell(s.ack.trans_en) |-> $past(STALL_DONE_I) &&
		$past(SOFTWARE_TRANSLATION_OP_IDLE_I) && !PRIQ_WRITE_EN_O && !WALK_ALLOW_O)
		else $error("disable acknowledged before side effects");

	a_stall_abort_hold: assert property (
		$rose(STALL_ABORT_O) |-> SOFTWARE_TRANSLATION_OP_ABORT_O && !WALK_ALLOW_O
		until $fell(s.ack.trans_en))
		else $error("abort requests dropped before disable ack");

	a_secure_apart: assert property (
		TXN_I.valid && TXN_I.secure |=> TXN_O.resp == TEA_RSP_OTHER_SIDE)
		else $error("secure traffic handled by this interface");

	a_vmw_decode: assert property (
		s.ack.vmid_wildcard > TEA_VMW_MAX |=> INV_VMID_IGNORE_O == TEA_RST_VMW)
		else $error("reserved wildcard code not treated as exact");

	a_ats_mode: assert property (
		TXN_I.valid && !TXN_I.secure && s.en_eff && !s.ack.ats_check &&
		TXN_I.kind == TEA_TXN_ATS_XLATED |=>
		TXN_O.resp == TEA_RSP_PASS_DIRECT)
		else $error("fast mode did not pass translated traffic");

	a_ack_reserved: assert property (
		apb_setup && PADDR_I == TEA_OFF_CONTROL_ACK |=>
		PRDATA_O[31:9] == 23'h00_0000 && !PRDATA_O[5])
		else $error("reserved ack bits not zero");

	a_cmdq_ack: assert property (
		$fell(s.ack.cmdq_en) |-> $past(CMDQ_IDLE_I) &&
		!$past(s.ctrl.cmdq_en))
		else $error("command queue ack cleared before idle");

endmodule : tea_top

/* File: bench/tea_far_model.sv */
// Far-side model: requesters issuing transactions, and one helper
// readiness level standing for the stall, software-op and queue units.
// Assumes the bench calls send() and kick() from its main thread.
`timescale 1ns/1ps
module tea_far_model
	import tea_pkg::*;
(
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	output      tea_txn_req_t txn_o,
	output      logic         ready_o
);
	int   cnt;
	int   dly;
	logic load;

	initial begin
		txn_o = '0;
		cnt = 0;
		dly = 0;
		load = 1'b0;
	end

	// Helpers stay busy dly cycles after each kick, to test slow answers
	always @(posedge clk_i) begin
		if (!rst_n_i || load)
			cnt <= 0;
		else if (cnt < dly)
			cnt <= cnt + 1;
	end
	assign ready_o = !load && (cnt >= dly);

	task automatic kick(input int d);
		dly = d;
		@(posedge clk_i);
		load <= 1'b1;
		@(posedge clk_i);
		load <= 1'b0;
	endtask : kick

	// One transaction lasts one cycle, valid drops at the next edge
	task automatic send(input tea_txn_kind_t k, input logic s);
		@(posedge clk_i);
		txn_o <= '{valid: 1'b1, kind: k, secure: s, substream: 1'b1};
		@(posedge clk_i);
		txn_o.valid <= 1'b0;
	endtask : send
endmodule : tea_far_model

/* File: bench/tea_top_tb.sv */
// Self-checking bench for the translation enable block.
// Assumes zero-wait APB and a far-side model for helper levels.
`timescale 1ns/1ps
module tea_top_tb;
	import tea_pkg::*;
	logic         clk = 1'b0;
	logic         arst_n = 1'b0;
	logic         psel = 1'b0;
	logic         penable = 1'b0;
	logic         pwrite = 1'b0;
	logic [11:0]  paddr = 12'h000;
	logic [31:0]  pwdata = 32'h0;
	logic [31:0]  prdata;
	logic         pready;
	logic         pslverr;
	tea_txn_req_t txn;
	tea_txn_out_t txo;
	tea_cmd_req_t cmd = '0;
	tea_cmd_out_t cmo;
	logic         rdy;
	logic         stall_ab, software_translation_op_ab, walk, evx, software_translation_op_ok, priq_w, cq, eq;
	logic [2:0]   vmi;
	int           fails = 0;
	int           check_count = 0;

	always #25 clk = ~clk;

	tea_far_model u_far (.clk_i(clk), .rst_n_i(arst_n), .txn_o(txn),
		.ready_o(rdy));

	tea_top u_dut (.CLK_I(clk), .ARST_N_I(arst_n), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PSTRB_I(4'hF), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .TXN_I(txn), .TXN_O(txo),
		.CMD_I(cmd), .CMD_O(cmo), .CR2_APPLIED_I(rdy), .SOFTWARE_TRANSLATION_OP_RUN_I(!rdy),
		.SOFTWARE_TRANSLATION_OP_IDLE_I(rdy), .STALL_DONE_I(rdy), .PRIQ_IDLE_I(rdy),
		.CMDQ_IDLE_I(rdy), .EVTQ_IDLE_I(rdy), .STALL_ABORT_O(stall_ab),
		.SOFTWARE_TRANSLATION_OP_ABORT_O(software_translation_op_ab), .WALK_ALLOW_O(walk),
		.EVENT_XLATE_EN_O(evx), .SOFTWARE_TRANSLATION_OP_ALLOW_O(software_translation_op_ok),
		.PRIQ_WRITE_EN_O(priq_w), .CMDQ_RUN_O(cq), .EVTQ_WRITE_O(eq),
		.INV_VMID_IGNORE_O(vmi));

	task automatic results();
		$display("checks=%0d mismatches=%0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		check_count++;
		if (g !== x) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			fails++;
			results();
		end
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, x);
	endtask : rd

	task automatic tx(input tea_txn_kind_t k, input logic s,
		input tea_txn_rsp_t x);
		u_far.send(k, s);
		#1;
		chk({28'h0, txo}, {28'h0, 1'b1, x});
	endtask : tx

	task automatic cm(input tea_cmd_kind_t k, input logic x);
		@(posedge clk);
		cmd <= '{valid: 1'b1, kind: k};
		@(posedge clk);
		cmd.valid <= 1'b0;
		#1;
		chk({30'h0, cmo}, {30'h0, 1'b1, x});
	endtask : cm

	// Polls the acknowledge enable bit with a bounded number of reads
	task automatic wait_ack(input logic v);
		logic [31:0] r;
		logic        e;
		int          n;
		n = 0;
		do begin
			apb(1'b0, TEA_OFF_CONTROL_ACK, 32'h0, r, e);
			n++;
		end while (r[0] !== v && n < 30);
		chk({31'h0, r[0]}, {31'h0, v});
		if (r[0] !== v)
			results();
	endtask : wait_ack

	// -----------------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------------
	task automatic t_regs();
		logic [31:0] r;
		logic        e;
		rd(TEA_OFF_CONTROL_ACK, 32'h0);
		wr(TEA_OFF_CONTROL_ACK, 32'hFFFF_FFFF);
		rd(TEA_OFF_CONTROL_ACK, 32'h0);
		apb(1'b0, 12'h100, 32'h0, r, e);
		chk({31'h0, e}, 32'h1);
		chk(r, 32'h0);
		$display("test regs done");
	endtask : t_regs

	task automatic t_off();
		wr(TEA_OFF_CONTROL, 32'h0000_000E);
		rd(TEA_OFF_CONTROL_ACK, 32'h0000_000E);
		chk({31'h0, priq_w}, 32'h0);
		chk({30'h0, cq, eq}, 32'h3);
		chk({29'h0, walk, evx, software_translation_op_ok}, 32'h0);
		for (int ab = 0; ab < 2; ab++) begin
			wr(TEA_OFF_BYPASS, 32'(ab));
			tx(TEA_TXN_NORMAL, 1'b0,
				ab ? TEA_RSP_ABORT : TEA_RSP_BYPASS);
		end
		tx(TEA_TXN_NORMAL, 1'b1, TEA_RSP_OTHER_SIDE);
		wr(TEA_OFF_BYPASS, 32'h0);
		tx(TEA_TXN_ATS_REQ, 1'b0, TEA_RSP_UNSUP_REQ);
		tx(TEA_TXN_ATS_XLATED, 1'b0, TEA_RSP_ABORT);
		tx(TEA_TXN_PRI_REQ, 1'b0, TEA_RSP_DISCARD);
		tx(TEA_TXN_INV_CPL, 1'b0, TEA_RSP_DISCARD);
		cm(TEA_ATC_INVALIDATE_CMD, 1'b0);
		cm(TEA_PAGE_REQUEST_RESPONSE_CMD, 1'b0);
		cm(TEA_CMD_PREFETCH, 1'b0);
		cm(TEA_CMD_OTHER, 1'b1);
		$display("test off done");
	endtask : t_off

	task automatic t_on();
		u_far.kick(12);
		wr(TEA_OFF_CONTROL, 32'h0000_00DF);
		rd(TEA_OFF_CONTROL_ACK, 32'h0000_00DE);
		chk({31'h0, walk}, 32'h0);
		wait_ack(1'b1);
		rd(TEA_OFF_CONTROL_ACK, 32'h0000_00DF);
		chk({28'h0, walk, evx, software_translation_op_ok, priq_w}, 32'hF);
		chk({29'h0, vmi}, 32'h3);
		tx(TEA_TXN_NORMAL, 1'b0, TEA_RSP_TRANSLATE);
		tx(TEA_TXN_ATS_XLATED, 1'b0, TEA_RSP_CHECK_ENTRY);
		tx(TEA_TXN_PRI_REQ, 1'b0, TEA_RSP_TRANSLATE);
		cm(TEA_ATC_INVALIDATE_CMD, 1'b1);
		wr(TEA_OFF_CONTROL, 32'h0000_014F);
		rd(TEA_OFF_CONTROL_ACK, 32'h0000_014F);
		chk({29'h0, vmi}, 32'h0);
		tx(TEA_TXN_ATS_XLATED, 1'b0, TEA_RSP_PASS_DIRECT);
		$display("test on done");
	endtask : t_on

	task automatic t_dis();
		u_far.kick(16);
		wr(TEA_OFF_CONTROL, 32'h0000_000E);
		repeat (2) @(posedge clk);
		#1;
		chk({29'h0, walk, stall_ab, software_translation_op_ab}, 32'h3);
		chk({31'h0, priq_w}, 32'h0);
		rd(TEA_OFF_CONTROL_ACK, 32'h0000_000F);
		wait_ack(1'b0);
		chk({30'h0, stall_ab, software_translation_op_ab}, 32'h0);
		tx(TEA_TXN_NORMAL, 1'b0, TEA_RSP_BYPASS);
		// Queue acks must hold while the helpers are still busy
		u_far.kick(10);
		wr(TEA_OFF_CONTROL, 32'h0000_0002);
		rd(TEA_OFF_CONTROL_ACK, 32'h0000_000E);
		chk({30'h0, cq, eq}, 32'h3);
		repeat (14) @(posedge clk);
		rd(TEA_OFF_CONTROL_ACK, 32'h0000_0002);
		chk({30'h0, cq, eq}, 32'h0);
		$display("test disable done");
	endtask : t_dis

	initial begin
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		t_regs();
		t_off();
		t_on();
		t_dis();
		results();
	end
endmodule : tea_top_tb
